// >>> rtl/orp_pkg.sv
// Constants and types for the over-range and power-mode register slice
// Summary of operation
// - Flag channel when magnitude reaches the unscaled threshold value
// - Flags forced low while enable bit clear
// - Stretch flag to four times two^N cycles
// - Status bit 0 shows initialization done
// - Code B: 0x06 low, 0x0F high
// - Code C: 0x00 low, 0x04 high
// - Code D: 0x14 low, 0x1B high
package orp_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int CHANNELS = 4;
   localparam int SAMPLE_W = 9;
   localparam int STRETCH_W = 3;
   localparam int COUNT_W = 10;
   localparam logic [ADDR_W-1:0] OFS_LIMIT = 12'h0211;
   localparam logic [ADDR_W-1:0] OFS_CONFIG = 12'h0213;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h0270;
   localparam logic [ADDR_W-1:0] OFS_CODE_B = 12'h029a;
   localparam logic [ADDR_W-1:0] OFS_CODE_C = 12'h029b;
   localparam logic [ADDR_W-1:0] OFS_CODE_D = 12'h029c;
   localparam logic [DATA_W-1:0] RST_LIMIT = 8'h00f2;
   localparam logic [DATA_W-1:0] RST_CONFIG = 8'h0007;
   localparam logic [DATA_W-1:0] RST_CODE_B = 8'h000f;
   localparam logic [DATA_W-1:0] RST_CODE_C = 8'h0004;
   localparam logic [DATA_W-1:0] RST_CODE_D = 8'h001b;
   localparam int CFG_ENABLE_BIT = 3;
   localparam int CFG_STRETCH_LSB = 0;
   localparam int STATUS_DONE_BIT = 0;
   localparam logic [COUNT_W-1:0] STRETCH_BASE = 10'h0004;
   localparam int INIT_CYCLES = 64;

   typedef struct packed {
      logic enable;
      logic [STRETCH_W-1:0] stretch;
   } orp_flag_cfg_type;

   typedef struct packed {
      logic write;
      logic read;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } orp_reg_req_type;
endpackage : orp_pkg

// >>> rtl/orp_stretch.sv
// One channel of over-range detection with pulse extension
`timescale 1ns/1ps
`default_nettype none
module orp_stretch (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [orp_pkg::SAMPLE_W-1:0] sample,
   input wire logic [orp_pkg::DATA_W-1:0] rangeLimitLevel,
   input wire orp_pkg::orp_flag_cfg_type cfg,
   output logic rangeFlag
);
   import orp_pkg::*;

   logic [COUNT_W-1:0] count_reg;
   logic [COUNT_W-1:0] count_next;
   logic flag_reg;
   logic flag_next;
   logic [SAMPLE_W-1:0] magnitude;
   logic hit;
   logic [COUNT_W-1:0] holdLen;

   // Full scale magnitude of 256 fits because the magnitude keeps the sign bit's width
   assign magnitude = sample[SAMPLE_W-1] ? SAMPLE_W'(-sample) : sample;
   assign hit = magnitude >= {1'b0, rangeLimitLevel};
   assign holdLen = COUNT_W'(STRETCH_BASE << cfg.stretch);
   assign count_next = !cfg.enable ? '0 : hit ? holdLen - 10'h0001
                     : (count_reg != '0) ? count_reg - 10'h0001 : '0;
   assign flag_next = cfg.enable & (hit | (count_reg != '0));
   assign rangeFlag = flag_reg;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         count_reg <= '0;
         flag_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         flag_reg <= flag_next;
      end
   end

   chk_flag_disabled: assert property (@(posedge sys_clk) disable iff (rst)
      !cfg.enable |=> !flag_reg) else $error("flag high while disabled");
   chk_hit_raises: assert property (@(posedge sys_clk) disable iff (rst)
      cfg.enable && hit |=> flag_reg) else $error("hit did not raise flag");
   chk_stretch_load: assert property (@(posedge sys_clk) disable iff (rst)
      cfg.enable && hit |=> count_reg == $past(holdLen) - 10'h0001)
      else $error("stretch count not restarted");
   chk_stretch_end: assert property (@(posedge sys_clk) disable iff (rst)
      cfg.enable && !hit && count_reg == 10'h0001 ##1 $stable(cfg) && !hit |=> !flag_reg)
      else $error("flag held past extension");
   chk_equal_level: assert property (@(posedge sys_clk) disable iff (rst)
      cfg.enable && magnitude == {1'b0, rangeLimitLevel} |=> flag_reg)
      else $error("equal magnitude not flagged");
endmodule : orp_stretch
`default_nettype wire

// >>> rtl/orp_regs.sv
// Over-range detection, startup status and power mode code registers
`timescale 1ns/1ps
`default_nettype none
module orp_regs #(
   parameter int INIT_LEN = orp_pkg::INIT_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire orp_pkg::orp_reg_req_type regReq,
   output logic [orp_pkg::DATA_W-1:0] regRdata,
   input wire logic [orp_pkg::CHANNELS*orp_pkg::SAMPLE_W-1:0] samples,
   output logic [orp_pkg::CHANNELS-1:0] rangeFlag,
   output logic initDone,
   output logic [orp_pkg::DATA_W-1:0] powerModeCodeB,
   output logic [orp_pkg::DATA_W-1:0] powerModeCodeC,
   output logic [orp_pkg::DATA_W-1:0] powerModeCodeD
);
   import orp_pkg::*;

   logic [DATA_W-1:0] limit_reg;
   logic [DATA_W-1:0] config_reg;
   logic [DATA_W-1:0] codeB_reg;
   logic [DATA_W-1:0] codeC_reg;
   logic [DATA_W-1:0] codeD_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;
   logic [15:0] initCount_reg;
   logic done_reg;
   logic [DATA_W-1:0] statusValue;
   orp_flag_cfg_type flagCfg;
   logic wrLimit;
   logic wrConfig;
   logic wrCodeB;
   logic wrCodeC;
   logic wrCodeD;

   assign wrLimit = regReq.write && regReq.addr == OFS_LIMIT;
   assign wrConfig = regReq.write && regReq.addr == OFS_CONFIG;
   assign wrCodeB = regReq.write && regReq.addr == OFS_CODE_B;
   assign wrCodeC = regReq.write && regReq.addr == OFS_CODE_C;
   assign wrCodeD = regReq.write && regReq.addr == OFS_CODE_D;

   // Reserved config bits are stored and read back; the host keeps them zero
   assign flagCfg.enable = config_reg[CFG_ENABLE_BIT];
   assign flagCfg.stretch = config_reg[CFG_STRETCH_LSB +: STRETCH_W];
   assign statusValue = {{(DATA_W-1){1'b0}}, done_reg};

   // Unmapped addresses read zero so a stray read is harmless
   assign rdata_next = !regReq.read ? rdata_reg
                     : (regReq.addr == OFS_LIMIT) ? limit_reg
                     : (regReq.addr == OFS_CONFIG) ? config_reg
                     : (regReq.addr == OFS_STATUS) ? statusValue
                     : (regReq.addr == OFS_CODE_B) ? codeB_reg
                     : (regReq.addr == OFS_CODE_C) ? codeC_reg
                     : (regReq.addr == OFS_CODE_D) ? codeD_reg
                     : '0;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         limit_reg <= RST_LIMIT;
         config_reg <= RST_CONFIG;
         codeB_reg <= RST_CODE_B;
         codeC_reg <= RST_CODE_C;
         codeD_reg <= RST_CODE_D;
         rdata_reg <= '0;
      end else begin
         if (wrLimit) begin
            limit_reg <= regReq.wdata;
         end
         if (wrConfig) begin
            config_reg <= regReq.wdata;
         end
         if (wrCodeB) begin
            codeB_reg <= regReq.wdata;
         end
         if (wrCodeC) begin
            codeC_reg <= regReq.wdata;
         end
         if (wrCodeD) begin
            codeD_reg <= regReq.wdata;
         end
         rdata_reg <= rdata_next;
      end
   end

   // Startup sequence: a fixed wait standing in for internal trimming
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         initCount_reg <= '0;
         done_reg <= 1'b0;
      end else if (!done_reg) begin
         initCount_reg <= initCount_reg + 16'h0001;
         done_reg <= initCount_reg == 16'(INIT_LEN - 1);
      end
   end

   generate
      for (genvar ch = 0; ch < CHANNELS; ch++) begin : gen_channel
         orp_stretch u_stretch (
            .sys_clk(sys_clk),
            .rst(rst),
            .sample(samples[ch*SAMPLE_W +: SAMPLE_W]),
            .rangeLimitLevel(limit_reg),
            .cfg(flagCfg),
            .rangeFlag(rangeFlag[ch])
         );
      end
   endgenerate

   assign regRdata = rdata_reg;
   assign initDone = done_reg;
   assign powerModeCodeB = codeB_reg;
   assign powerModeCodeC = codeC_reg;
   assign powerModeCodeD = codeD_reg;

   chk_status_read: assert property (@(posedge sys_clk) disable iff (rst)
      regReq.read && regReq.addr == OFS_STATUS |=> regRdata == {7'h00, $past(done_reg)})
      else $error("status readback wrong");
   chk_done_sticks: assert property (@(posedge sys_clk) disable iff (rst)
      done_reg |=> done_reg) else $error("init done dropped");
   chk_mode_defaults: assert property (@(posedge sys_clk)
      $past(rst) |-> codeB_reg == 8'h0f && codeC_reg == 8'h04 && codeD_reg == 8'h1b)
      else $error("mode code defaults wrong");
   chk_code_b_write: assert property (@(posedge sys_clk) disable iff (rst)
      wrCodeB |=> codeB_reg == $past(regReq.wdata)) else $error("code B not stored");
   chk_code_c_write: assert property (@(posedge sys_clk) disable iff (rst)
      wrCodeC |=> codeC_reg == $past(regReq.wdata)) else $error("code C not stored");
   chk_flags_disabled: assert property (@(posedge sys_clk) disable iff (rst)
      !flagCfg.enable ##1 !flagCfg.enable |-> rangeFlag == 4'h0)
      else $error("flags high while disabled");

   // Every stored register must take a write and hold otherwise
   chk_limit_write: assert property (@(posedge sys_clk) disable iff (rst)
      wrLimit |=> limit_reg == $past(regReq.wdata)) else $error("threshold not stored");

   chk_limit_holds: assert property (@(posedge sys_clk) disable iff (rst)
      !wrLimit |=> $stable(limit_reg)) else $error("threshold changed without write");

   chk_config_write: assert property (@(posedge sys_clk) disable iff (rst)
      wrConfig |=> config_reg == $past(regReq.wdata)) else $error("config not stored");

   chk_config_holds: assert property (@(posedge sys_clk) disable iff (rst)
      !wrConfig |=> $stable(config_reg)) else $error("config changed without write");

   chk_code_d_write: assert property (@(posedge sys_clk) disable iff (rst)
      wrCodeD |=> codeD_reg == $past(regReq.wdata)) else $error("code D not stored");

   chk_code_b_holds: assert property (@(posedge sys_clk) disable iff (rst)
      !wrCodeB |=> $stable(codeB_reg)) else $error("code B changed without write");

   chk_code_c_holds: assert property (@(posedge sys_clk) disable iff (rst)
      !wrCodeC |=> $stable(codeC_reg)) else $error("code C changed without write");

   chk_code_d_holds: assert property (@(posedge sys_clk) disable iff (rst)
      !wrCodeD |=> $stable(codeD_reg)) else $error("code D changed without write");

   // Readback of each mapped register, one cycle after the taking edge
   chk_limit_read: assert property (@(posedge sys_clk) disable iff (rst)
      regReq.read && regReq.addr == OFS_LIMIT |=> regRdata == $past(limit_reg))
      else $error("threshold readback wrong");

   chk_config_read: assert property (@(posedge sys_clk) disable iff (rst)
      regReq.read && regReq.addr == OFS_CONFIG |=> regRdata == $past(config_reg))
      else $error("config readback wrong");

   chk_code_b_read: assert property (@(posedge sys_clk) disable iff (rst)
      regReq.read && regReq.addr == OFS_CODE_B |=> regRdata == $past(codeB_reg))
      else $error("code B readback wrong");

   chk_code_c_read: assert property (@(posedge sys_clk) disable iff (rst)
      regReq.read && regReq.addr == OFS_CODE_C |=> regRdata == $past(codeC_reg))
      else $error("code C readback wrong");

   chk_code_d_read: assert property (@(posedge sys_clk) disable iff (rst)
      regReq.read && regReq.addr == OFS_CODE_D |=> regRdata == $past(codeD_reg))
      else $error("code D readback wrong");

   chk_rdata_holds: assert property (@(posedge sys_clk) disable iff (rst)
      !regReq.read |=> $stable(regRdata)) else $error("read data moved without read");

   // Status is read-only: a write there must leave threshold, config, code B and init done alone
   chk_status_ro: assert property (@(posedge sys_clk) disable iff (rst)
      regReq.write && regReq.addr == OFS_STATUS |=> $stable(limit_reg)
      && $stable(config_reg) && $stable(codeB_reg) && $stable(done_reg))
      else $error("status write had an effect");

   // The startup wait must end on its last count and not before
   chk_done_rises: assert property (@(posedge sys_clk) disable iff (rst)
      !done_reg && initCount_reg == 16'(INIT_LEN - 1) |=> done_reg)
      else $error("init done late");

   chk_done_waits: assert property (@(posedge sys_clk) disable iff (rst)
      !done_reg && initCount_reg != 16'(INIT_LEN - 1) |=> !done_reg)
      else $error("init done early");

   // Reset leaves printed defaults, quiet flags and no pending status
   chk_reset_defaults: assert property (@(posedge sys_clk)
      $past(rst) |-> limit_reg == 8'hf2 && config_reg == 8'h07)
      else $error("threshold or config default wrong");

   chk_reset_quiet: assert property (@(posedge sys_clk)
      $past(rst) |-> rangeFlag == 4'h0 && !done_reg && regRdata == 8'h00)
      else $error("outputs not cleared by reset");
endmodule : orp_regs
`default_nettype wire

// >>> dv/orp_host_model.sv
// Register host model that drives the decoded register port
`timescale 1ns/1ps
`default_nettype none
module orp_host_model (
   input wire logic sys_clk,
   output var orp_pkg::orp_reg_req_type regReq
);
   import orp_pkg::*;
   initial regReq = '0;
   // Idle cycle after each request; released fields are inverted, not kept
   task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(negedge sys_clk);
      regReq = '{write: w, read: !w, addr: a, wdata: d};
      @(negedge sys_clk);
      regReq = '{write: 1'b0, read: 1'b0, addr: ~a, wdata: ~d};
   endtask : access
   task automatic wrCfg(input logic en, input logic [2:0] n);
      access(1'b1, OFS_CONFIG, {4'h0, en, n});
   endtask : wrCfg
   // All three codes move together, legal codes only
   // The bench clock sits below the low-power rate limit; calibration and link
   // enables live outside this slice and stay off, so no recalibration is due here
   task automatic setMode(input logic low);
      access(1'b1, OFS_CODE_B, low ? 8'h06 : 8'h0f);
      access(1'b1, OFS_CODE_C, low ? 8'h00 : 8'h04);
      access(1'b1, OFS_CODE_D, low ? 8'h14 : 8'h1b);
   endtask : setMode
endmodule : orp_host_model
`default_nettype wire

// >>> dv/orp_regs_tb_top.sv
// Self-checking testbench for the over-range and power-mode registers
`timescale 1ns/1ps
`default_nettype none
module orp_regs_tb_top;
   import orp_pkg::*;
   logic sys_clk, rst, initDone, took;
   orp_reg_req_type regReq;
   logic [7:0] regRdata, codeB, codeC, codeD;
   logic [35:0] samples;
   logic [3:0] rangeFlag;
   logic [7:0] expQ[$];
   int miscompares = 0, tests_run = 0, seed = 32'h00dd, i, m;
   orp_host_model host (.sys_clk(sys_clk), .regReq(regReq));
   orp_regs #(.INIT_LEN(4)) uut (.sys_clk(sys_clk), .rst(rst), .regReq(regReq),
      .regRdata(regRdata), .samples(samples), .rangeFlag(rangeFlag), .initDone(initDone),
      .powerModeCodeB(codeB), .powerModeCodeC(codeC), .powerModeCodeD(codeD));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : tally_and_finish
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      expQ.push_back(exp);
      host.access(1'b0, a, 8'h00);
   endtask : rd
   // Read data lands on the taking edge and is checked on the falling edge after it
   always @(posedge sys_clk) took <= regReq.read;
   always @(negedge sys_clk) begin
      if (took && expQ.size() > 0) check(regRdata, expQ.pop_front());
   end
   task automatic hit(input int ch, input logic [8:0] s, input int len);
      @(negedge sys_clk);
      samples[ch*9 +: 9] = s;
      @(negedge sys_clk);
      samples = '0;
      for (i = 0; i <= len; i++) begin
         if (i > 0) @(negedge sys_clk);
         check(8'(rangeFlag), i < len ? 8'(1 << ch) : 8'h00);
      end
   endtask : hit
   initial begin
      rst = 1'b1;
      samples = '0;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      check(8'(initDone), 8'h00);
      for (i = 0; i < 20 && initDone !== 1'b1; i++) @(negedge sys_clk);
      if (initDone !== 1'b1) begin
         miscompares++;
         tally_and_finish();
      end
      rd(OFS_STATUS, 8'h01);
      host.access(1'b1, OFS_STATUS, 8'hff);
      rd(OFS_STATUS, 8'h01);
      rd(OFS_LIMIT, 8'hf2);
      rd(OFS_CONFIG, 8'h07);
      rd(12'h212, 8'h00);
      $display("reset and status test done");
      for (m = 1; m >= 0; m--) begin
         host.setMode(m[0]);
         check(codeB, m ? 8'h06 : 8'h0f);
         check(codeC, m ? 8'h00 : 8'h04);
         check(codeD, m ? 8'h14 : 8'h1b);
         rd(OFS_CODE_B, m ? 8'h06 : 8'h0f);
         rd(OFS_CODE_C, m ? 8'h00 : 8'h04);
         rd(OFS_CODE_D, m ? 8'h14 : 8'h1b);
      end
      $display("mode code test done");
      host.access(1'b1, OFS_LIMIT, 8'h80);
      hit(0, 9'h080, 0);
      host.wrCfg(1'b1, 3'd0);
      rd(OFS_CONFIG, 8'h08);
      hit(0, 9'h080, 4);
      hit(1, 9'h180, 4);
      hit(2, 9'h07f, 0);
      @(negedge sys_clk);
      samples[26:18] = 9'h081;
      hit(2, 9'h081, 4);
      for (m = 0; m < 16; m++) begin
         @(negedge sys_clk);
         for (i = 0; i < 4; i++) samples[i*9 +: 9] = 9'($random(seed) % 128);
         @(negedge sys_clk);
         check(8'(rangeFlag), 8'h00);
      end
      samples = '0;
      host.access(1'b1, OFS_LIMIT, 8'hff);
      host.wrCfg(1'b1, 3'd1);
      hit(3, 9'h100, 8);
      $display("over-range test done");
      tally_and_finish();
   end
endmodule : orp_regs_tb_top
`default_nettype wire
